/* File: inc/iep_pkg.sv */
// Package with register map, bit positions, reset values and carriers for the interrupt block.
package iep_pkg;
	// Register page and addresses in the special-function space.
	localparam logic [7:0] IEP_PAGE_EXT = 8'h10;
	localparam logic [7:0] IEP_PAGE_BASE = 8'h00;
	localparam logic [7:0] IEP_ADDR_PRIO_LOW = 8'hBB;
	localparam logic [7:0] IEP_ADDR_PRIO_HIGH = 8'hEE;
	localparam logic [7:0] IEP_ADDR_ENABLE = 8'hE6;

	// Values after reset.
	localparam logic [7:0] IEP_RST_PRIO_LOW = 8'h00;
	localparam logic [7:0] IEP_RST_PRIO_HIGH = 8'h00;
	localparam logic [7:0] IEP_RST_ENABLE = 8'h00;
	localparam logic [7:0] IEP_RST_RDATA = 8'h00;

	// Bit position of each source in all three registers.
	localparam int IEP_BIT_TWOWIRE = 0;
	localparam int IEP_BIT_PORT_MATCH = 1;
	localparam int IEP_BIT_WINDOW = 2;
	localparam int IEP_BIT_CONV_DONE = 3;
	localparam int IEP_BIT_COUNTER_ARRAY = 4;
	localparam int IEP_BIT_COMP_ZERO = 5;
	localparam int IEP_BIT_COMP_ONE = 6;
	localparam int IEP_BIT_TIMER_THREE = 7;

	// Number of sources and width of a source index.
	localparam int IEP_NUM_SRC = 8;
	localparam int IEP_SRC_W = 3;

	// One special-function register access from the core.
	typedef struct packed
	{
		logic [7:0] page;
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} iep_sfr_req_t;

	// Request offered to the core: source and its two-bit priority.
	typedef struct packed
	{
		logic valid;
		logic [IEP_SRC_W-1:0] src;
		logic [1:0] prio;
	} iep_grant_t;

	// True when an access addresses the given register.
	function automatic logic iep_hit(iep_sfr_req_t req, logic [7:0] page, logic [7:0] addr);
		return (req.page == page) && (req.addr == addr);
	endfunction : iep_hit
endpackage : iep_pkg

/* File: hw/iep_arbiter.sv */
// Priority selection among enabled pending interrupt sources.
module iep_arbiter
	import iep_pkg::*;
#(
	parameter int N = IEP_NUM_SRC,
	parameter int W = $clog2(N)
)
(
	input wire logic [N-1:0] req,
	input wire logic [N-1:0] prio_high,
	input wire logic [N-1:0] prio_low,
	output logic valid,
	output logic [W-1:0] src,
	output logic [1:0] prio
);
	// The index width must hold every source.
	if (N < 2 || (1 << W) < N)
	begin : g_bad_param
		$error("iep_arbiter: N and W do not fit");
	end

	// Highest two-bit value wins; an equal value keeps the lower index, so
	// ties resolve in a fixed order and never toggle between sources.
	always_comb
	begin
		logic [1:0] p;
		p = 2'h0;
		valid = 1'b0;
		src = '0;
		prio = 2'h0;
		for (int i = 0; i < N; i++)
		begin
			p = {prio_high[i], prio_low[i]};
			if (req[i] && (!valid || p > prio))
			begin
				valid = 1'b1;
				src = W'(i);
				prio = p;
			end
		end
	end
endmodule : iep_arbiter

/* File: hw/iep_regs.sv */
// Extended interrupt enable and priority registers with request selection.
// Operation
// - Enable bit 2 masks the window compare interrupt: 0 blocks it, 1 lets its flag request.
// - Enable bit 1 gates port match interrupts: 0 blocks them, 1 lets a match request.
// - Enable bit 0 gates the two-wire serial interrupts: 0 blocks them, 1 passes them all.
// - The low priority register sits on page 0x10 at 0xBB, eight RW bits resetting to zero.
// - Low priority bit 7 is the priority LSB of the timer three interrupt.
// - Low priority bit 6 is the priority LSB of the comparator one interrupt.
// - Low priority bit 5 is the priority LSB of the comparator zero interrupt.
// - Low priority bit 4 is the priority LSB of the counter array interrupt.
// - Low priority bit 2 is the priority LSB of the window compare interrupt.
// - Low priority bit 1 is the priority LSB of the port match interrupt.
// - Low priority bit 0 is the priority LSB of the two-wire serial interrupt.
// - The high priority register at 0xEE gives each source's MSB in the same bit order.
module iep_regs
	import iep_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire iep_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata,
	input wire logic [IEP_NUM_SRC-1:0] src_flag,
	input wire logic svc_active,
	input wire logic [1:0] svc_prio,
	output logic [7:0] irq_enable,
	output logic [7:0] prio_low,
	output logic [7:0] prio_high,
	output iep_grant_t irq_grant
);
	logic [7:0] enable_r;
	logic [7:0] prio_low_r;
	logic [7:0] prio_high_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	iep_grant_t grant_r;
	iep_grant_t grant_nxt;
	logic [IEP_NUM_SRC-1:0] gated;
	logic sel_valid;
	logic [IEP_SRC_W-1:0] sel_src;
	logic [1:0] sel_prio;
	logic hit_low;
	logic hit_high;
	logic hit_en;

	// Address decode; the enable register answers on both pages so that
	// code running in either page can mask sources without a page switch.
	assign hit_low = iep_hit(sfr_req, IEP_PAGE_EXT, IEP_ADDR_PRIO_LOW);
	assign hit_high = iep_hit(sfr_req, IEP_PAGE_EXT, IEP_ADDR_PRIO_HIGH);
	assign hit_en = iep_hit(sfr_req, IEP_PAGE_EXT, IEP_ADDR_ENABLE)
		|| iep_hit(sfr_req, IEP_PAGE_BASE, IEP_ADDR_ENABLE);

	// Enable register.
	always_ff @(posedge clk)
	begin
		if (!resetn)
			enable_r <= IEP_RST_ENABLE;
		else if (sfr_req.wr && hit_en)
			enable_r <= sfr_req.wdata;
	end

	// Low-order priority register; all bits read-write.
	always_ff @(posedge clk)
	begin
		if (!resetn)
			prio_low_r <= IEP_RST_PRIO_LOW;
		else if (sfr_req.wr && hit_low)
			prio_low_r <= sfr_req.wdata;
	end

	// High-order priority register, same bit order as the low one.
	always_ff @(posedge clk)
	begin
		if (!resetn)
			prio_high_r <= IEP_RST_PRIO_HIGH;
		else if (sfr_req.wr && hit_high)
			prio_high_r <= sfr_req.wdata;
	end

	// Read data; a read in the same cycle as a write returns the old value.
	always_comb
	begin
		rdata_nxt = IEP_RST_RDATA;
		if (hit_low)
			rdata_nxt = prio_low_r;
		else if (hit_high)
			rdata_nxt = prio_high_r;
		else if (hit_en)
			rdata_nxt = enable_r;
	end

	// Read data register; it holds until the next read.
	always_ff @(posedge clk)
	begin
		if (!resetn)
			rdata_r <= IEP_RST_RDATA;
		else if (sfr_req.rd)
			rdata_r <= rdata_nxt;
	end

	// Masking of each source by its enable bit.
	always_comb
	begin
		gated = src_flag & enable_r;
		gated[IEP_BIT_WINDOW] = src_flag[IEP_BIT_WINDOW] && enable_r[IEP_BIT_WINDOW];
		gated[IEP_BIT_PORT_MATCH] = src_flag[IEP_BIT_PORT_MATCH]
			&& enable_r[IEP_BIT_PORT_MATCH];
		gated[IEP_BIT_TWOWIRE] = src_flag[IEP_BIT_TWOWIRE] && enable_r[IEP_BIT_TWOWIRE];
	end

	// Each source's field is {high bit, low bit} at its own position.
	iep_arbiter #(
		.N(IEP_NUM_SRC),
		.W(IEP_SRC_W)
	) u_arbiter (
		.req(gated),
		.prio_high(prio_high_r),
		.prio_low(prio_low_r),
		.valid(sel_valid),
		.src(sel_src),
		.prio(sel_prio)
	);

	// A request reaches the core only if it outranks the routine in service;
	// equal priority never preempts, which keeps nesting depth bounded.
	always_comb
	begin
		grant_nxt.src = sel_src;
		grant_nxt.prio = sel_prio;
		grant_nxt.valid = sel_valid && (!svc_active || sel_prio > svc_prio);
	end

	// Registered request towards the core.
	always_ff @(posedge clk)
	begin
		if (!resetn)
			grant_r <= '0;
		else
			grant_r <= grant_nxt;
	end

	assign sfr_rdata = rdata_r;
	assign irq_enable = enable_r;
	assign prio_low = prio_low_r;
	assign prio_high = prio_high_r;
	assign irq_grant = grant_r;

	// Helper: true when some enabled pending source outranks the selection.
	logic outranked;
	always_comb
	begin
		outranked = 1'b0;
		for (int i = 0; i < IEP_NUM_SRC; i++)
		begin
			if (gated[i] && {prio_high_r[i], prio_low_r[i]} > sel_prio)
				outranked = 1'b1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	property p_window_block;
		!enable_r[IEP_BIT_WINDOW] |=> !(grant_r.valid && grant_r.src == 3'h2);
	endproperty
	a_window_block: assert property (p_window_block)
		else $error("window compare passed while masked");

	property p_window_pass;
		(gated == 8'h04 && !svc_active) |=> (grant_r.valid && grant_r.src == 3'h2);
	endproperty
	a_window_pass: assert property (p_window_pass)
		else $error("enabled window compare not requested");

	property p_match_block;
		!enable_r[IEP_BIT_PORT_MATCH] |=> !(grant_r.valid && grant_r.src == 3'h1);
	endproperty
	a_match_block: assert property (p_match_block)
		else $error("port match passed while masked");

	property p_twowire_block;
		!enable_r[IEP_BIT_TWOWIRE] |=> !(grant_r.valid && grant_r.src == 3'h0);
	endproperty
	a_twowire_block: assert property (p_twowire_block)
		else $error("two-wire request passed while masked");

	property p_low_write;
		(sfr_req.wr && sfr_req.page == 8'h10 && sfr_req.addr == 8'hBB)
			|=> prio_low_r == $past(sfr_req.wdata);
	endproperty
	a_low_write: assert property (p_low_write)
		else $error("low priority write not stored");

	property p_low_read;
		(sfr_req.rd && !sfr_req.wr && sfr_req.page == 8'h10 && sfr_req.addr == 8'hBB)
			|=> sfr_rdata == $past(prio_low_r);
	endproperty
	a_low_read: assert property (p_low_read)
		else $error("low priority read returns wrong data");

	property p_high_write;
		(sfr_req.wr && sfr_req.page == 8'h10 && sfr_req.addr == 8'hEE)
			|=> prio_high_r == $past(sfr_req.wdata);
	endproperty
	a_high_write: assert property (p_high_write)
		else $error("high priority write not stored");

	property p_field_map;
		sel_valid |-> sel_prio == {prio_high_r[sel_src], prio_low_r[sel_src]};
	endproperty
	a_field_map: assert property (p_field_map)
		else $error("selected priority not from its own bit pair");

	property p_highest_first;
		sel_valid |-> !outranked;
	endproperty
	a_highest_first: assert property (p_highest_first)
		else $error("lower priority selected over higher");

	property p_preempt;
		grant_r.valid |-> (!$past(svc_active) || grant_r.prio > $past(svc_prio));
	endproperty
	a_preempt: assert property (p_preempt)
		else $error("request did not outrank routine in service");

	c_window: cover property (grant_r.valid && grant_r.src == 3'h2);
	c_preempt: cover property (svc_active && grant_nxt.valid);
	c_blocked: cover property (sel_valid && svc_active && !grant_nxt.valid);
	c_timer_top: cover property (grant_r.valid && grant_r.src == 3'h7 && grant_r.prio == 2'h3);
endmodule : iep_regs

/* File: sim/iep_regs_tb.sv */
// Self-checking testbench for the interrupt enable and priority registers.
module iep_regs_tb
	import iep_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	iep_sfr_req_t sfr_req = '0;
	logic [7:0] src_flag = 8'h00;
	logic svc_active = 1'b0;
	logic [1:0] svc_prio = 2'h0;
	logic [7:0] sfr_rdata, irq_enable, prio_low, prio_high;
	iep_grant_t irq_grant;
	logic [7:0] m_en, m_lo, m_hi;
	logic [7:0] exp_q[$];
	logic gprobe = 1'b0;
	logic rd_seen = 1'b0;
	int fail_count = 0;
	int comparisons = 0;
	logic [15:0] spots[6] = '{16'h10BB, 16'h10EE, 16'h00E6, 16'h10E6, 16'h00BB, 16'h1055};

	iep_regs i_dut (.clk(clk), .resetn(resetn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.src_flag(src_flag), .svc_active(svc_active), .svc_prio(svc_prio),
		.irq_enable(irq_enable), .prio_low(prio_low), .prio_high(prio_high),
		.irq_grant(irq_grant));

	// Free-running 125 MHz clock.
	initial
	begin
		forever #4 clk = ~clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// An empty queue here means the design answered something nobody asked for; the
	// expected value always differs from what was seen, so an unknown cannot slip through.
	task automatic take(input logic [7:0] seen);
		if (exp_q.size() == 0)
			check(seen, (seen === 8'h00) ? 8'hFF : 8'h00);
		else
			check(seen, exp_q.pop_front());
	endtask : take

	function automatic logic [7:0] rd_exp(input logic [7:0] p, input logic [7:0] a);
		if (p == IEP_PAGE_EXT && a == IEP_ADDR_PRIO_LOW) return m_lo;
		if (p == IEP_PAGE_EXT && a == IEP_ADDR_PRIO_HIGH) return m_hi;
		if ((p == IEP_PAGE_EXT || p == IEP_PAGE_BASE) && a == IEP_ADDR_ENABLE) return m_en;
		return 8'h00;
	endfunction : rd_exp

	// Descending scan with >= lets the lowest index win a tie.
	function automatic logic [7:0] grant_exp(input logic [7:0] f, input logic act,
		input logic [1:0] sp);
		logic [7:0] g;
		g = 8'h00;
		for (int i = IEP_NUM_SRC - 1; i >= 0; i--)
			if (f[i] && m_en[i] && {m_hi[i], m_lo[i]} >= g[1:0])
				g = {2'h0, 1'b1, i[2:0], m_hi[i], m_lo[i]};
		if (act && g[1:0] <= sp) g = 8'h00;
		return g;
	endfunction : grant_exp

	// One strobe per call; the expected read is noted before the model takes any write.
	task automatic bus(input logic [7:0] p, input logic [7:0] a, input logic w, input logic r,
		input logic [7:0] d);
		@(posedge clk);
		sfr_req <= '{page: p, addr: a, wr: w, rd: r, wdata: d};
		if (r) exp_q.push_back(rd_exp(p, a));
		if (w && p == IEP_PAGE_EXT && a == IEP_ADDR_PRIO_LOW) m_lo = d;
		if (w && p == IEP_PAGE_EXT && a == IEP_ADDR_PRIO_HIGH) m_hi = d;
		if (w && (p == IEP_PAGE_EXT || p == IEP_PAGE_BASE) && a == IEP_ADDR_ENABLE) m_en = d;
	endtask : bus

	task automatic regs(input logic [7:0] en, input logic [7:0] lo, input logic [7:0] hi);
		bus(IEP_PAGE_BASE, IEP_ADDR_ENABLE, 1'b1, 1'b0, en);
		bus(IEP_PAGE_EXT, IEP_ADDR_PRIO_LOW, 1'b1, 1'b0, lo);
		bus(IEP_PAGE_EXT, IEP_ADDR_PRIO_HIGH, 1'b1, 1'b0, hi);
	endtask : regs

	task automatic rd_all;
		foreach (spots[i]) bus(spots[i][15:8], spots[i][7:0], 1'b0, 1'b1, 8'h00);
	endtask : rd_all

	// Flags are held two edges so the registered grant reflects them at the probe.
	task automatic gchk(input logic [7:0] f, input logic act, input logic [1:0] sp);
		@(posedge clk);
		sfr_req <= '0;
		src_flag <= f;
		svc_active <= act;
		svc_prio <= sp;
		@(posedge clk);
		exp_q.push_back(grant_exp(f, act, sp));
		exp_q.push_back(m_en);
		exp_q.push_back(m_lo);
		exp_q.push_back(m_hi);
		gprobe <= 1'b1;
		@(posedge clk);
		gprobe <= 1'b0;
	endtask : gchk

	task automatic do_reset;
		@(posedge clk);
		sfr_req <= '0;
		resetn <= 1'b0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		m_en = 8'h00;
		m_lo = 8'h00;
		m_hi = 8'h00;
	endtask : do_reset

	// Results are looked at mid-cycle, long after the launching edge has settled.
	always @(posedge clk) rd_seen <= sfr_req.rd & resetn;
	always @(negedge clk)
	begin
		if (rd_seen) take(sfr_rdata);
		if (gprobe)
		begin
			take(irq_grant.valid ? {2'h0, irq_grant} : 8'h00);
			take(irq_enable);
			take(prio_low);
			take(prio_high);
		end
	end

	task automatic results;
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	// A hang is cut short here and counted as a mismatch.
	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		$display("mismatch at %0t: seen %h expected %h", $time, 8'h00, 8'hFF);
		results();
	end

	initial
	begin
		void'($urandom(52));
		do_reset();
		rd_all();
		foreach (spots[i]) bus(spots[i][15:8], spots[i][7:0], 1'b1, 1'b0, 8'($urandom));
		rd_all();
		bus(IEP_PAGE_EXT, IEP_ADDR_PRIO_LOW, 1'b1, 1'b1, 8'hA5);
		rd_all();
		$display("test registers done");
		for (int i = 0; i < IEP_NUM_SRC; i++)
		begin
			regs(8'h01 << i, 8'h01 << i, 8'h00);
			gchk(8'hFF, 1'b0, 2'h0);
			regs(8'h01 << i, 8'h00, 8'h01 << i);
			gchk(8'hFF, 1'b0, 2'h0);
			regs(~(8'h01 << i), 8'hFF, 8'hFF);
			gchk(8'h01 << i, 1'b0, 2'h0);
		end
		$display("test source bits done");
		regs(8'hFF, 8'h0F, 8'hF0);
		for (int s = 0; s < 4; s++) gchk(8'hFF, 1'b1, 2'(s));
		$display("test preemption done");
		repeat (60)
		begin
			regs(8'($urandom), 8'($urandom), 8'($urandom));
			gchk(8'($urandom), 1'($urandom), 2'($urandom));
			bus(spots[$urandom % 6][15:8], spots[$urandom % 6][7:0], 1'b0, 1'b1, 8'h00);
		end
		$display("test random done");
		do_reset();
		rd_all();
		gchk(8'hFF, 1'b0, 2'h0);
		$display("test second reset done");
		bus(8'h00, 8'h00, 1'b0, 1'b0, 8'h00);
		repeat (3) @(posedge clk);
		if (exp_q.size() != 0) check(8'(exp_q.size()), 8'h00);
		results();
	end
endmodule : iep_regs_tb
